/* File: hw/pfes_pkg.sv */
package pfes_pkg;

  // ****************************************
  // Bus and register map
  // ****************************************
  localparam int        ADDR_W       = 5;
  localparam int        DATA_W       = 32;
  localparam logic [4:0] REG_CTRL    = 5'h00;
  localparam logic [4:0] REG_KEY     = 5'h04;
  localparam logic [4:0] REG_STATUS  = 5'h08;
  localparam logic [4:0] REG_MASK    = 5'h0c;
  localparam logic [4:0] REG_ROW     = 5'h10;
  localparam logic [4:0] REG_BUF     = 5'h14;

  // ****************************************
  // Control fields
  // ****************************************
  localparam int         CTL_OP_LSB  = 0;
  localparam int         CTL_ERASE   = 6;
  localparam int         CTL_PERMIT  = 14;
  localparam int         CTL_WR      = 15;
  localparam logic [3:0] OP_ERASE    = 4'h2;
  localparam logic [3:0] OP_PROG     = 4'h1;
  localparam logic [3:0] OP_RESET    = 4'h0;
  localparam logic [7:0] KEY_FIRST   = 8'h55;
  localparam logic [7:0] KEY_SECOND  = 8'haa;

  // ****************************************
  // Status and interrupt bits
  // ****************************************
  localparam int         EV_W        = 2;
  localparam int         EV_DONE     = 0;
  localparam int         EV_REFUSED  = 1;
  localparam int         ST_BUSY     = 8;
  localparam logic [1:0] EV_RESET    = 2'h0;

  // ****************************************
  // Flash geometry
  // ****************************************
  localparam int         ROW_WORDS   = 64;
  localparam int         WORD_IDX_W  = 6;
  localparam int         PAGE_ROWS   = 8;
  localparam int         PAGE_LSB_W  = 3;
  localparam int         ROW_W       = 10;
  localparam int         INSTR_W     = 24;

  // ****************************************
  // Timing
  // ****************************************
  localparam int         CLK_MHZ       = 25;
  localparam int         ERASE_TIME_US = 20;
  localparam int         ROW_TIME_US   = 2;
  localparam int         ERASE_CYCLES  = ERASE_TIME_US * CLK_MHZ;
  localparam int         ROW_CYCLES    = ROW_TIME_US * CLK_MHZ;
  localparam int         TMR_W         = 16;

  typedef enum logic [1:0] {UK_IDLE, UK_HALF, UK_ARMED} pfes_key_state_t;
  typedef enum logic [1:0] {SQ_IDLE, SQ_ERASE, SQ_COPY, SQ_PWAIT} pfes_seq_state_t;

endpackage : pfes_pkg

/* File: hw/pfes_unlock.sv */
`timescale 1ns/1ps
module pfes_unlock (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Bus write events
  input  wire logic       key_wr,
  input  wire logic [7:0] key_data,
  input  wire logic       other_wr,
  // Unlock state
  output logic            armed
);
  import pfes_pkg::*;

  typedef struct packed {
    pfes_key_state_t state;
  } pfes_unlock_regs_t;

  pfes_unlock_regs_t r;
  pfes_unlock_regs_t next_r;

  always_comb begin
    next_r = r;
    if (key_wr) begin
      case (r.state)
        UK_IDLE:  next_r.state = (key_data == KEY_FIRST) ? UK_HALF : UK_IDLE;
        UK_HALF:  next_r.state = (key_data == KEY_SECOND) ? UK_ARMED : UK_IDLE;
        default:  next_r.state = UK_IDLE;
      endcase
    end else if (other_wr) begin
      // Any other write breaks the back-to-back sequence
      next_r.state = UK_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r.state <= UK_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign armed = (r.state == UK_ARMED);

  a_key_order_arms:   assert property (@(posedge clk) disable iff (!rst_n)
    key_wr && r.state == UK_HALF && key_data == KEY_SECOND |=> armed)
    else $error("second key after first did not arm");
  a_bad_key_resets:   assert property (@(posedge clk) disable iff (!rst_n)
    key_wr && !(r.state == UK_IDLE && key_data == KEY_FIRST)
    && !(r.state == UK_HALF && key_data == KEY_SECOND) |=> !armed && r.state != UK_HALF)
    else $error("unexpected key did not reset sequence");

endmodule : pfes_unlock

/* File: hw/pfes_timer.sv */
`timescale 1ns/1ps
module pfes_timer #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  // Expiry pulse
  output logic                  done
);
  import pfes_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             done;
  } pfes_timer_regs_t;

  pfes_timer_regs_t r;
  pfes_timer_regs_t next_r;

  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    if (load) begin
      next_r.cnt = load_val;
    end else if (r.cnt != '0) begin
      next_r.cnt  = r.cnt - 1'b1;
      next_r.done = (r.cnt == {{(CNT_W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign done = r.done;

endmodule : pfes_timer

/* File: hw/pfes_top.sv */
// Local design decisions: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module pfes_top (
  // Clock and reset
  input  wire logic                             clk,
  input  wire logic                             rst_n,
  // Avalon-MM slave
  input  wire logic [pfes_pkg::ADDR_W-1:0]      address,
  input  wire logic                             read,
  input  wire logic                             write,
  input  wire logic [3:0]                       byteenable,
  input  wire logic [pfes_pkg::DATA_W-1:0]      writedata,
  output logic      [pfes_pkg::DATA_W-1:0]      readdata,
  output logic                                  waitrequest,
  // Processor and interrupt
  output logic                                  cpu_stall,
  output logic                                  irq,
  // Flash array
  output logic                                  flash_erase,
  output logic                                  flash_write,
  output logic [pfes_pkg::ROW_W+pfes_pkg::WORD_IDX_W-1:0] flash_addr,
  output logic [pfes_pkg::INSTR_W-1:0]          flash_wdata
);
  import pfes_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    pfes_seq_state_t         state;
    logic [3:0]              op;
    logic                    erase;
    logic                    permit;
    logic                    wr;
    logic [EV_W-1:0]         status;
    logic [EV_W-1:0]         mask;
    logic [ROW_W-1:0]        row;
    logic [WORD_IDX_W-1:0]   buf_idx;
    logic [WORD_IDX_W-1:0]   word;
    logic                    waitreq;
    logic [DATA_W-1:0]       rdata;
    logic                    stall;
    logic                    irq;
    logic                    fl_erase;
    logic                    fl_write;
    logic [ROW_W+WORD_IDX_W-1:0] fl_addr;
    logic [INSTR_W-1:0]      fl_data;
  } pfes_top_regs_t;

  pfes_top_regs_t r;
  pfes_top_regs_t next_r;

  // Holding buffer kept out of the state word to stay a plain memory
  logic [INSTR_W-1:0] hold_buf [ROW_WORDS];

  logic             wr_taken;
  logic             key_wr;
  logic             other_wr;
  logic             armed;
  logic             tmr_load;
  logic [TMR_W-1:0] tmr_val;
  logic             tmr_done;
  logic             buf_wr;
  logic             start;
  logic             op_ok;
  logic             new_permit;
  logic             new_erase;
  logic [3:0]       new_op;
  logic [EV_W-1:0]  ev_set;
  logic [EV_W-1:0]  ev_clr;

  // Access takes effect in the cycle waitrequest is low
  assign wr_taken = write && !r.waitreq;
  assign key_wr   = wr_taken && (address == REG_KEY) && byteenable[0];
  assign other_wr = wr_taken && !key_wr;

  // ****************************************
  // Submodules
  // ****************************************
  pfes_unlock u_unlock (
    .clk      (clk),
    .rst_n    (rst_n),
    .key_wr   (key_wr),
    .key_data (writedata[7:0]),
    .other_wr (other_wr),
    .armed    (armed)
  );

  pfes_timer #(
    .CNT_W (TMR_W)
  ) u_timer (
    .clk      (clk),
    .rst_n    (rst_n),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done     (tmr_done)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    next_r     = r;
    tmr_load   = 1'b0;
    tmr_val    = '0;
    buf_wr     = 1'b0;
    start      = 1'b0;
    ev_set     = '0;
    ev_clr     = '0;
    new_op     = byteenable[0] ? writedata[CTL_OP_LSB +: 4] : r.op;
    new_erase  = byteenable[0] ? writedata[CTL_ERASE] : r.erase;
    new_permit = byteenable[1] ? writedata[CTL_PERMIT] : r.permit;
    // Mismatched operation and erase-select pairs are refused, never run
    op_ok      = ((new_op == OP_ERASE) && new_erase)
              || ((new_op == OP_PROG) && !new_erase);

    // Single wait state on every access, answer on the second cycle
    next_r.waitreq  = !((read || write) && r.waitreq);
    next_r.fl_erase = 1'b0;
    next_r.fl_write = 1'b0;

    if (read && r.waitreq) begin
      case (address)
        REG_CTRL: begin
          next_r.rdata = '0;
          next_r.rdata[CTL_OP_LSB +: 4] = r.op;
          next_r.rdata[CTL_ERASE]       = r.erase;
          next_r.rdata[CTL_PERMIT]      = r.permit;
          next_r.rdata[CTL_WR]          = r.wr;
        end
        REG_STATUS: begin
          next_r.rdata = '0;
          next_r.rdata[EV_W-1:0] = r.status;
          next_r.rdata[ST_BUSY]  = (r.state != SQ_IDLE);
        end
        REG_MASK:   next_r.rdata = {{(DATA_W-EV_W){1'b0}}, r.mask};
        REG_ROW:    next_r.rdata = {{(DATA_W-ROW_W){1'b0}}, r.row};
        default:    next_r.rdata = '0;
      endcase
    end

    if (wr_taken) begin
      case (address)
        REG_CTRL: begin
          // Control is frozen while an operation runs
          if (r.state == SQ_IDLE) begin
            next_r.op     = new_op;
            next_r.erase  = new_erase;
            next_r.permit = new_permit;
            if (byteenable[1] && writedata[CTL_WR]) begin
              if (new_permit && armed && op_ok) begin
                start = 1'b1;
              end else begin
                ev_set[EV_REFUSED] = 1'b1;
              end
            end
          end
        end
        REG_STATUS: if (byteenable[0]) ev_clr = writedata[EV_W-1:0];
        REG_MASK:   if (byteenable[0]) next_r.mask = writedata[EV_W-1:0];
        REG_ROW: begin
          if (r.state == SQ_IDLE && byteenable[0] && byteenable[1]) begin
            next_r.row = writedata[ROW_W-1:0];
          end
        end
        REG_BUF: begin
          if (r.state == SQ_IDLE) begin
            buf_wr         = 1'b1;
            next_r.buf_idx = r.buf_idx + 1'b1;
          end
        end
        default: ;
      endcase
    end

    case (r.state)
      SQ_IDLE: begin
        if (start) begin
          next_r.wr    = 1'b1;
          next_r.stall = 1'b1;
          if (new_op == OP_ERASE) begin
            // Whole aligned page goes, not just the addressed row
            next_r.fl_erase = 1'b1;
            next_r.fl_addr  = {r.row[ROW_W-1:PAGE_LSB_W], {PAGE_LSB_W{1'b0}},
                               {WORD_IDX_W{1'b0}}};
            tmr_load        = 1'b1;
            tmr_val         = TMR_W'(ERASE_CYCLES);
            next_r.state    = SQ_ERASE;
          end else begin
            next_r.word  = '0;
            next_r.state = SQ_COPY;
          end
        end
      end
      SQ_ERASE: begin
        if (tmr_done) begin
          next_r.wr          = 1'b0;
          next_r.stall       = 1'b0;
          ev_set[EV_DONE]    = 1'b1;
          next_r.state       = SQ_IDLE;
        end
      end
      SQ_COPY: begin
        // One buffered instruction per cycle into the addressed row
        next_r.fl_write = 1'b1;
        next_r.fl_addr  = {r.row, r.word};
        next_r.fl_data  = hold_buf[r.word];
        next_r.word     = r.word + 1'b1;
        // Timer armed on the last word so the wait follows the burst
        if (r.word == WORD_IDX_W'(ROW_WORDS - 1)) begin
          tmr_load     = 1'b1;
          tmr_val      = TMR_W'(ROW_CYCLES);
          next_r.state = SQ_PWAIT;
        end
      end
      SQ_PWAIT: begin
        if (tmr_done) begin
          next_r.wr       = 1'b0;
          next_r.stall    = 1'b0;
          next_r.buf_idx  = '0;
          ev_set[EV_DONE] = 1'b1;
          next_r.state    = SQ_IDLE;
        end
      end
      default: next_r.state = SQ_IDLE;
    endcase

    // Hardware set wins over a software clear in the same cycle
    next_r.status = (r.status & ~ev_clr) | ev_set;
    next_r.irq    = |(next_r.status & next_r.mask);
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r         <= '0;
      r.state   <= SQ_IDLE;
      r.op      <= OP_RESET;
      r.status  <= EV_RESET;
      r.mask    <= EV_RESET;
      r.waitreq <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Loads only while idle, so a running copy reads a stable row
  always_ff @(posedge clk) begin
    if (buf_wr) begin
      hold_buf[r.buf_idx] <= writedata[INSTR_W-1:0];
    end
  end

  assign readdata    = r.rdata;
  assign waitrequest = r.waitreq;
  assign cpu_stall   = r.stall;
  assign irq         = r.irq;
  assign flash_erase = r.fl_erase;
  assign flash_write = r.fl_write;
  assign flash_addr  = r.fl_addr;
  assign flash_wdata = r.fl_data;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_start_needs_key:  assert property ($rose(cpu_stall) |-> $past(armed))
    else $error("operation started without unlock");
  a_key_reads_zero:   assert property (read && r.waitreq && address == REG_KEY
    |=> readdata == '0) else $error("key register read not zero");
  a_erase_page_align: assert property (flash_erase
    |-> flash_addr[PAGE_LSB_W+WORD_IDX_W-1:0] == '0) else $error("erase not page aligned");
  a_erase_op_bits:    assert property (flash_erase |-> r.op == OP_ERASE && r.erase
    && r.permit && r.wr) else $error("erase with wrong control bits");
  a_prog_op_bits:     assert property ($rose(flash_write) |-> r.op == OP_PROG
    && !r.erase && r.permit) else $error("program with wrong control bits");
  a_row_burst_len:    assert property ($rose(flash_write) |-> flash_write[*8]
    ##0 (flash_addr[WORD_IDX_W-1:0] == 6'h07)) else $error("row burst broken");
  a_burst_end:        assert property (flash_write && flash_addr[WORD_IDX_W-1:0] == 6'h3f
    |=> !flash_write) else $error("row burst longer than a row");
  a_wr_self_clear:    assert property ($fell(cpu_stall) |-> !r.wr
    && r.status[EV_DONE]) else $error("start bit not cleared at end");
  a_stall_holds:      assert property ($rose(cpu_stall) |-> cpu_stall[*8])
    else $error("stall released too early");
  a_no_permit_refuse: assert property (wr_taken && address == REG_CTRL && r.state == SQ_IDLE
    && byteenable[1] && writedata[CTL_WR] && !writedata[CTL_PERMIT]
    |=> !cpu_stall && !r.wr && r.status[EV_REFUSED]) else $error("start without permit");

  // Refusals leave the array and the start bit alone
  a_no_key_refuse:    assert property (wr_taken && address == REG_CTRL && r.state == SQ_IDLE
    && byteenable[1] && writedata[CTL_WR] && !armed
    |=> !cpu_stall && !r.wr && r.status[EV_REFUSED]) else $error("start without unlock");
  a_bad_op_refuse:    assert property (wr_taken && address == REG_CTRL && r.state == SQ_IDLE
    && byteenable[1] && writedata[CTL_WR] && !op_ok
    |=> !cpu_stall && !r.wr && r.status[EV_REFUSED]) else $error("start with bad operation");

  // Control and buffer stay frozen while an operation runs
  a_busy_ctrl_frozen: assert property (wr_taken && address == REG_CTRL && r.state != SQ_IDLE
    |=> $stable(r.op) && $stable(r.erase) && $stable(r.permit))
    else $error("control changed while busy");
  a_busy_buf_frozen:  assert property (wr_taken && address == REG_BUF && r.state != SQ_IDLE
    && !tmr_done |=> $stable(r.buf_idx)) else $error("buffer loaded while busy");
  a_start_reads_one:  assert property (cpu_stall |-> r.wr)
    else $error("start bit low while running");

  // Shape of the flash side commands, and release at the end of a program
  a_erase_one_pulse:  assert property (flash_erase |=> !flash_erase)
    else $error("erase pulse longer than one cycle");
  a_burst_one_row:    assert property (flash_write && $past(flash_write)
    |-> $stable(flash_addr[ROW_W+WORD_IDX_W-1:WORD_IDX_W])) else $error("burst changed row");
  a_prog_end_clear:   assert property (r.state == SQ_PWAIT && tmr_done
    |=> !cpu_stall && !r.wr && r.status[EV_DONE]) else $error("program end not released");

  // ****************************************
  // Cover properties
  // ****************************************
  c_erase_done:  cover property (r.state == SQ_ERASE ##1 r.state == SQ_IDLE);
  c_prog_done:   cover property (r.state == SQ_PWAIT ##1 r.state == SQ_IDLE);
  c_refused:     cover property ($rose(r.status[EV_REFUSED]));
  c_irq:         cover property ($rose(irq));
  c_busy_write:  cover property (wr_taken && address == REG_CTRL && r.state != SQ_IDLE);

endmodule : pfes_top

/* File: tb/pfes_top_tb.sv */
`timescale 1ns/1ps
module pfes_top_tb;
  import pfes_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  logic                clk;
  logic                rst_n;
  logic [ADDR_W-1:0]   address;
  logic                read;
  logic                write;
  logic [3:0]          byteenable;
  logic [DATA_W-1:0]   writedata;
  logic [DATA_W-1:0]   readdata;
  logic                waitrequest;
  logic                cpu_stall;
  logic                irq;
  logic                flash_erase;
  logic                flash_write;
  logic [15:0]         flash_addr;
  logic [INSTR_W-1:0]  flash_wdata;
  int                  err_count;
  int                  cmp_count;
  int                  seed;
  int                  stall_n;
  int                  row_m;
  int                  buf_q[$];
  logic [15:0]         er_q[$];
  logic [15:0]         wa_q[$];
  logic [INSTR_W-1:0]  wd_q[$];

  pfes_top dut_u (
    .clk         (clk),
    .rst_n       (rst_n),
    .address     (address),
    .read        (read),
    .write       (write),
    .byteenable  (byteenable),
    .writedata   (writedata),
    .readdata    (readdata),
    .waitrequest (waitrequest),
    .cpu_stall   (cpu_stall),
    .irq         (irq),
    .flash_erase (flash_erase),
    .flash_write (flash_write),
    .flash_addr  (flash_addr),
    .flash_wdata (flash_wdata)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Flash side observed at every edge, before the edge's own updates
  always @(posedge clk) begin
    if (flash_erase === 1'b1) er_q.push_back(flash_addr);
    if (flash_write === 1'b1) begin
      wa_q.push_back(flash_addr);
      wd_q.push_back(flash_wdata);
    end
    if (cpu_stall === 1'b1) stall_n++;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    read       <= ~wr;
    write      <= wr;
    address    <= a;
    writedata  <= d;
    byteenable <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    if (n >= 100) err_count++;
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr32(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr32

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd_chk

  task automatic launch(input logic [31:0] ctrl);
    wr32(REG_KEY, 32'(KEY_FIRST));
    wr32(REG_KEY, 32'(KEY_SECOND));
    wr32(REG_CTRL, ctrl);
  endtask : launch

  // Refused launch: sticky flag only, nothing reaches the array
  task automatic refused_chk();
    repeat (3) @(posedge clk);
    chk(32'(stall_n + er_q.size() + wa_q.size()), 32'h0);
    rd_chk(REG_STATUS, 32'h2);
    wr32(REG_STATUS, 32'h2);
  endtask : refused_chk

  task automatic wait_op();
    int n;
    n = 0;
    while (cpu_stall !== 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    while (cpu_stall !== 1'b0 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 5000) err_count++;
    repeat (2) @(posedge clk);
  endtask : wait_op

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    #(40 * 20000);
    err_count++;
    end_sim();
  end

  initial begin
    int d;
    int pr;
    {rst_n, read, write, byteenable, address, writedata} = '0;
    err_count = 0;
    cmp_count = 0;
    stall_n = 0;
    seed = 36341;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    buf_q.delete();
    for (int a = 0; a < 8; a++) rd_chk(5'(a * 4), 32'h0);
    wr32(REG_KEY, 32'h55);
    rd_chk(REG_KEY, 32'h0);
    // Start after the first key alone, interrupt masked
    wr32(REG_CTRL, 32'hc042);
    refused_chk();
    wr32(REG_MASK, 32'h2);
    wr32(REG_CTRL, 32'hc042);
    @(posedge clk);
    chk(32'(irq), 32'h1);
    wr32(REG_STATUS, 32'h2);
    @(posedge clk);
    chk(32'(irq), 32'h0);
    // Wrong middle key, a write between key and start, permit clear
    wr32(REG_KEY, 32'h55);
    wr32(REG_KEY, 32'h12);
    wr32(REG_KEY, 32'haa);
    wr32(REG_CTRL, 32'hc042);
    refused_chk();
    wr32(REG_KEY, 32'h55);
    wr32(REG_KEY, 32'haa);
    wr32(REG_MASK, 32'h2);
    wr32(REG_CTRL, 32'hc042);
    refused_chk();
    launch(32'h8042);
    refused_chk();
    // Erase code without erase select, program code with it
    launch(32'hc002);
    refused_chk();
    launch(32'hc041);
    refused_chk();
    // Page erase on a random row, control written while busy is ignored
    row_m = $random(seed) & 32'h3ff;
    wr32(REG_ROW, 32'(row_m));
    wr32(REG_MASK, 32'h1);
    wr32(REG_CTRL, 32'h4042);
    launch(32'hc042);
    repeat (3) @(posedge clk);
    chk(32'(cpu_stall), 32'h1);
    rd_chk(REG_STATUS, 32'h100);
    wr32(REG_CTRL, 32'h0);
    rd_chk(REG_CTRL, 32'hc042);
    wait_op();
    chk(32'(er_q.size()), 32'h1);
    if (er_q.size() > 0) chk(32'(er_q[0]), 32'((row_m & 32'h3f8) << 6));
    chk(32'(wa_q.size()), 32'h0);
    chk(32'(stall_n >= ERASE_CYCLES), 32'h1);
    rd_chk(REG_CTRL, 32'h4042);
    chk(32'(irq), 32'h1);
    rd_chk(REG_STATUS, 32'h1);
    wr32(REG_STATUS, 32'h1);
    // First two rows of the erased page written back one after the other
    for (int k = 0; k < 2; k++) begin
      stall_n = 0;
      buf_q.delete();
      wa_q.delete();
      wd_q.delete();
      for (int i = 0; i < ROW_WORDS; i++) begin
        d = $random(seed);
        buf_q.push_back(d & 32'hffffff);
        wr32(REG_BUF, 32'(d));
      end
      pr = (row_m & 32'h3f8) | k;
      wr32(REG_ROW, 32'(pr));
      launch(32'hc001);
      wait_op();
      chk(32'(wa_q.size()), 32'(ROW_WORDS));
      for (int i = 0; i < ROW_WORDS && i < wa_q.size(); i++) begin
        chk(32'(wa_q[i]), 32'((pr << 6) | i));
        chk(32'(wd_q[i]), 32'(buf_q[i]));
      end
      chk(32'(stall_n >= ROW_WORDS + ROW_CYCLES), 32'h1);
      chk(32'(er_q.size()), 32'h1);
      rd_chk(REG_CTRL, 32'h4001);
      rd_chk(REG_STATUS, 32'h1);
      wr32(REG_STATUS, 32'h1);
    end
    @(posedge clk);
    chk(32'(irq), 32'h0);
    end_sim();
  end

endmodule : pfes_top_tb
